// >>> core/rtf_fmt.sv
// Result formatter: offset add, saturation, signed and unsigned bytes
`timescale 1ns/1ns
`default_nettype none
module rtf_fmt
    import rtf_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    rtf_fmt_if.fmt    fi
);

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic [RTF_BYTE_W-1:0] s_high;
        logic [RTF_BYTE_W-1:0] s_low;
        logic [RTF_BYTE_W-1:0] u_high;
        logic [RTF_BYTE_W-1:0] u_low;
    } rtf_fmt_s;

    rtf_fmt_s                     st_q;
    rtf_fmt_s                     st_d;
    logic signed [RTF_SUM_W-1:0]  sum;
    logic signed [RTF_SUM_W-1:0]  sat_s;
    logic signed [RTF_SUM_W-1:0]  sat_u;
    logic [RTF_FRAC_LOW_W-1:0]    s_frac_lo;
    logic [RTF_FRAC_LOW_W-1:0]    u_frac_lo;

    assign sum = $signed({fi.conv_raw[RTF_RAW_W-1], fi.conv_raw})
               + $signed({{2{fi.offset[RTF_OFS_W-1]}}, fi.offset,
                          RTF_FRAC_ZERO});

    // Next result, taken only on a finished conversion
    always_comb begin
        st_d = st_q;
        if (sum > RTF_S_MAX) begin
            sat_s = RTF_S_MAX;
        end else if (sum < RTF_S_MIN) begin
            sat_s = RTF_S_MIN;
        end else begin
            sat_s = sum;
        end
        if (sum > RTF_U_MAX) begin
            sat_u = RTF_U_MAX;
        end else if (sum < RTF_U_MIN) begin
            sat_u = RTF_U_MIN;
        end else begin
            sat_u = sum;
        end
        s_frac_lo = RTF_FRAC_ZERO;
        if (fi.ext_en && !fi.filt_en) begin
            s_frac_lo = (sum > RTF_EXT_TH) ? RTF_FRAC_ONES : RTF_FRAC_ZERO;
        end else if (fi.ext_en && fi.filt_en) begin
            s_frac_lo = sat_s[RTF_FRAC_LOW_W-1:0];
        end
        u_frac_lo = RTF_FRAC_ZERO;
        if (fi.filt_en) begin
            u_frac_lo = sat_u[RTF_FRAC_LOW_W-1:0];
        end
        if (fi.conv_valid) begin
            st_d.s_high = sat_s[RTF_RES_W-1:RTF_INT_LSB];
            st_d.s_low  = {sat_s[RTF_INT_LSB-1:RTF_FRAC_TOP_LSB],
                           s_frac_lo, RTF_UNUSED_VAL};
            st_d.u_high = sat_u[RTF_RES_W-1:RTF_INT_LSB];
            st_d.u_low  = {sat_u[RTF_INT_LSB-1:RTF_FRAC_TOP_LSB],
                           u_frac_lo, RTF_UNUSED_VAL};
        end
    end

    // Result registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= '{RTF_BYTE_RST, RTF_BYTE_RST, RTF_BYTE_RST, RTF_BYTE_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign fi.s_high = st_q.s_high;
    assign fi.s_low  = st_q.s_low;
    assign fi.u_high = st_q.u_high;
    assign fi.u_low  = st_q.u_low;

endmodule
`default_nettype wire

// >>> core/rtf_top.sv
// Remote temperature result registers behind an AHB-Lite slave
`timescale 1ns/1ns
`default_nettype none
module rtf_top
    import rtf_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [RTF_DATA_W-1:0] haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [RTF_DATA_W-1:0] hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [RTF_DATA_W-1:0]      hrdata,
    output logic                       hresp,
    input  wire logic                  conv_valid,
    input  wire logic [RTF_RAW_W-1:0]  conv_raw
);

    // ************************************************
    // State
    // ************************************************
    typedef struct packed {
        logic                  wr_pend;   // Write data phase pending
        logic [RTF_IDX_W-1:0]  wr_idx;    // Index of pending write
        logic [RTF_OFS_W-1:0]  offset;    // Remote offset, 1/8 C
        logic                  ext_en;    // extended_resolution_enable
        logic                  filt_en;   // Digital filter enable
        logic                  s_lock;    // Signed high read, low pending
        logic [RTF_BYTE_W-1:0] s_shadow;  // Signed low at high read
        logic                  u_lock;    // Unsigned high read, low pending
        logic [RTF_BYTE_W-1:0] u_shadow;  // Unsigned low at high read
        logic [RTF_DATA_W-1:0] rdata;     // Read data for data phase
    } rtf_top_s;

    rtf_top_s             st_q;
    rtf_top_s             st_d;
    logic                 addr_ok;
    logic                 rd_go;
    logic                 wr_go;
    logic [RTF_IDX_W-1:0] a_idx;
    logic [RTF_BYTE_W-1:0] rd_byte;

    rtf_fmt_if fif ();

    // ************************************************
    // Decode helper
    // ************************************************
    // Same index compare serves read mux, side effects and writes
    function automatic logic rtf_hit(
        input logic [RTF_IDX_W-1:0] idx,
        input logic [RTF_IDX_W-1:0] reg_idx
    );
        rtf_hit = (idx == reg_idx);
    endfunction

    // ************************************************
    // Formatter
    // ************************************************
    // Offset and enables come straight from the register state, conversion inputs from the ports
    assign fif.conv_valid = conv_valid;
    assign fif.conv_raw   = conv_raw;
    assign fif.offset     = st_q.offset;
    assign fif.filt_en    = st_q.filt_en;
    assign fif.ext_en     = st_q.ext_en;

    rtf_fmt u_fmt (
        .hclk    (hclk),
        .hresetn (hresetn),
        .fi      (fif)
    );

    // ************************************************
    // Address phase
    // ************************************************
    // Upper haddr bits must be zero so aliases do not alias registers
    assign a_idx   = haddr[RTF_IDX_W+RTF_IDX_LSB-1:RTF_IDX_LSB];
    assign addr_ok = (haddr[RTF_DATA_W-1:RTF_IDX_W+RTF_IDX_LSB] == '0);
    assign rd_go   = hsel && htrans[RTF_HTRANS_ACT] && hready && !hwrite;
    assign wr_go   = hsel && htrans[RTF_HTRANS_ACT] && hready && hwrite;

    // Read mux, low bytes come from the shadow while a pair is open
    always_comb begin
        rd_byte = RTF_BYTE_RST;
        if (!addr_ok) begin
            rd_byte = RTF_BYTE_RST;
        end else if (rtf_hit(a_idx, RTF_IDX_SIGNED_HIGH)) begin
            rd_byte = fif.s_high;
        end else if (rtf_hit(a_idx, RTF_IDX_SIGNED_LOW)) begin
            rd_byte = st_q.s_lock ? st_q.s_shadow : fif.s_low;
        end else if (rtf_hit(a_idx, RTF_IDX_UNSIGNED_HIGH)) begin
            rd_byte = fif.u_high;
        end else if (rtf_hit(a_idx, RTF_IDX_UNSIGNED_LOW)) begin
            rd_byte = st_q.u_lock ? st_q.u_shadow : fif.u_low;
        end else if (rtf_hit(a_idx, RTF_IDX_OFFSET_HIGH)) begin
            rd_byte = st_q.offset[RTF_OFS_W-1:RTF_OFS_LOW_W];
        end else if (rtf_hit(a_idx, RTF_IDX_OFFSET_LOW)) begin
            rd_byte = RTF_BYTE_RST;
            rd_byte[RTF_OFS_LOW_MSB:RTF_OFS_LOW_LSB] =
                st_q.offset[RTF_OFS_LOW_W-1:0];
        end else if (rtf_hit(a_idx, RTF_IDX_CONFIG)) begin
            rd_byte = RTF_BYTE_RST;
            rd_byte[RTF_CFG_EXT_BIT]  = st_q.ext_en;
            rd_byte[RTF_CFG_FILT_BIT] = st_q.filt_en;
        end
    end

    // ************************************************
    // Next state
    // ************************************************
    always_comb begin
        st_d = st_q;

        // Data phase of a write; narrow writes are dropped silently
        if (st_q.wr_pend && hready) begin
            st_d.wr_pend = 1'b0;
            if (rtf_hit(st_q.wr_idx, RTF_IDX_OFFSET_HIGH)) begin
                st_d.offset[RTF_OFS_W-1:RTF_OFS_LOW_W] =
                    hwdata[RTF_BYTE_W-1:0];
            end else if (rtf_hit(st_q.wr_idx, RTF_IDX_OFFSET_LOW)) begin
                st_d.offset[RTF_OFS_LOW_W-1:0] =
                    hwdata[RTF_OFS_LOW_MSB:RTF_OFS_LOW_LSB];
            end else if (rtf_hit(st_q.wr_idx, RTF_IDX_CONFIG)) begin
                st_d.ext_en  = hwdata[RTF_CFG_EXT_BIT];
                st_d.filt_en = hwdata[RTF_CFG_FILT_BIT];
            end
        end

        // New write address phase; result registers are read only
        if (wr_go) begin
            st_d.wr_pend = addr_ok && (hsize == RTF_HSIZE_WORD);
            st_d.wr_idx  = a_idx;
        end

        // Read data is registered so hrdata is a flop in the data phase
        if (rd_go) begin
            st_d.rdata = {{(RTF_DATA_W-RTF_BYTE_W){1'b0}}, rd_byte};
        end

        if (rd_go && addr_ok && rtf_hit(a_idx, RTF_IDX_SIGNED_HIGH)) begin
            st_d.s_lock   = 1'b1;
            st_d.s_shadow = fif.s_low;
        end else if (rd_go && addr_ok
                     && rtf_hit(a_idx, RTF_IDX_SIGNED_LOW)) begin
            st_d.s_lock = 1'b0;
        end
        if (rd_go && addr_ok && rtf_hit(a_idx, RTF_IDX_UNSIGNED_HIGH)) begin
            st_d.u_lock   = 1'b1;
            st_d.u_shadow = fif.u_low;
        end else if (rd_go && addr_ok
                     && rtf_hit(a_idx, RTF_IDX_UNSIGNED_LOW)) begin
            st_d.u_lock = 1'b0;
        end
    end

    // ************************************************
    // Registers
    // ************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q.wr_pend  <= 1'b0;
            st_q.wr_idx   <= '0;
            st_q.offset   <= RTF_OFS_RST;
            st_q.ext_en   <= 1'b0;
            st_q.filt_en  <= 1'b0;
            st_q.s_lock   <= 1'b0;
            st_q.s_shadow <= RTF_BYTE_RST;
            st_q.u_lock   <= 1'b0;
            st_q.u_shadow <= RTF_BYTE_RST;
            st_q.rdata    <= RTF_DATA_ZERO;
        end else begin
            st_q <= st_d;
        end
    end

    // ************************************************
    // Bus answers
    // ************************************************
    // Zero wait states, so the slave never stalls the bus
    assign hreadyout = 1'b1;
    assign hresp     = RTF_HRESP_OKAY;
    assign hrdata    = st_q.rdata;

endmodule
`default_nettype wire

// >>> shared/rtf_fmt_if.sv
// Interface between the bus side and the result formatter
`timescale 1ns/1ns
`default_nettype none
interface rtf_fmt_if;
    import rtf_pkg::*;

    logic                  conv_valid;
    logic [RTF_RAW_W-1:0]  conv_raw;
    logic [RTF_OFS_W-1:0]  offset;
    logic                  filt_en;
    logic                  ext_en;
    logic [RTF_BYTE_W-1:0] s_high;
    logic [RTF_BYTE_W-1:0] s_low;
    logic [RTF_BYTE_W-1:0] u_high;
    logic [RTF_BYTE_W-1:0] u_low;

    // Bus side drives controls and reads the results
    modport ctrl (
        output conv_valid,
        output conv_raw,
        output offset,
        output filt_en,
        output ext_en,
        input  s_high,
        input  s_low,
        input  u_high,
        input  u_low
    );

    // Formatter side
    modport fmt (
        input  conv_valid,
        input  conv_raw,
        input  offset,
        input  filt_en,
        input  ext_en,
        output s_high,
        output s_low,
        output u_high,
        output u_low
    );

endinterface
`default_nettype wire

// >>> shared/rtf_pkg.sv
// Constants and register map for the remote temperature result formatter
package rtf_pkg;

    // ************************************************
    // Widths
    // ************************************************
    localparam int RTF_BYTE_W = 8;
    localparam int RTF_RAW_W  = 14;  // Converter output, signed, 1/32 C
    localparam int RTF_SUM_W  = 15;  // Raw plus offset, one guard bit
    localparam int RTF_RES_W  = 13;  // Result as presented, 1/32 C
    localparam int RTF_OFS_W  = 11;  // Offset, signed, 1/8 C
    localparam int RTF_IDX_W  = 10;  // Register index taken from haddr
    localparam int RTF_IDX_LSB = 2;  // Word aligned: index is haddr / 4
    localparam int RTF_DATA_W = 32;

    // ************************************************
    // Register indices (byte address is four times the index)
    // ************************************************
    localparam logic [RTF_IDX_W-1:0] RTF_IDX_SIGNED_HIGH   = 10'h001;
    localparam logic [RTF_IDX_W-1:0] RTF_IDX_SIGNED_LOW    = 10'h010;
    localparam logic [RTF_IDX_W-1:0] RTF_IDX_OFFSET_HIGH   = 10'h011;
    localparam logic [RTF_IDX_W-1:0] RTF_IDX_OFFSET_LOW    = 10'h012;
    localparam logic [RTF_IDX_W-1:0] RTF_IDX_UNSIGNED_HIGH = 10'h031;
    localparam logic [RTF_IDX_W-1:0] RTF_IDX_UNSIGNED_LOW  = 10'h032;
    localparam logic [RTF_IDX_W-1:0] RTF_IDX_CONFIG        = 10'h045;

    // ************************************************
    // Field positions
    // ************************************************
    localparam int RTF_CFG_EXT_BIT  = 0;  // extended_resolution_enable
    localparam int RTF_CFG_FILT_BIT = 1;  // Digital filter enable
    localparam int RTF_OFS_LOW_MSB  = 7;  // Offset low bits in low reg
    localparam int RTF_OFS_LOW_LSB  = 5;
    localparam int RTF_OFS_LOW_W    = 3;
    localparam int RTF_INT_LSB      = 5;  // Integer part starts at 1 C
    localparam int RTF_FRAC_TOP_LSB = 2;  // 0.125 C bit of the result
    localparam int RTF_FRAC_LOW_W   = 2;  // 0.0625 and 0.03125 C bits
    localparam int RTF_UNUSED_W     = 3;  // Bits 2:0 of each low byte

    // ************************************************
    // Limits in 1/32 C units at sum width
    // ************************************************
    localparam logic signed [RTF_SUM_W-1:0] RTF_S_MAX  = 15'sh0FFF;
    localparam logic signed [RTF_SUM_W-1:0] RTF_S_MIN  = 15'sh7000;
    localparam logic signed [RTF_SUM_W-1:0] RTF_U_MAX  = 15'sh1FFF;
    localparam logic signed [RTF_SUM_W-1:0] RTF_U_MIN  = 15'sh0000;
    localparam logic signed [RTF_SUM_W-1:0] RTF_EXT_TH = 15'sh0FFC;

    // ************************************************
    // Reset values and bus codes
    // ************************************************
    localparam logic [RTF_BYTE_W-1:0] RTF_BYTE_RST   = 8'h00;
    localparam logic [RTF_OFS_W-1:0]  RTF_OFS_RST    = 11'h000;
    localparam logic [RTF_DATA_W-1:0] RTF_DATA_ZERO  = 32'h00000000;
    localparam logic [1:0]            RTF_FRAC_ZERO  = 2'h0;
    localparam logic [1:0]            RTF_FRAC_ONES  = 2'h3;
    localparam logic [2:0]            RTF_UNUSED_VAL = 3'h0;
    localparam int                    RTF_HTRANS_ACT = 1;
    localparam logic [2:0]            RTF_HSIZE_WORD = 3'h2;
    localparam logic                  RTF_HRESP_OKAY = 1'b0;

endpackage

// >>> tb/rtf_host.sv
// Bus master model standing in for the host that reads results
`timescale 1ns/1ns
`default_nettype none
module rtf_host
    import rtf_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hready,
    input  wire logic [RTF_DATA_W-1:0] hrdata,
    output logic                       hsel,
    output logic [RTF_DATA_W-1:0]      haddr,
    output logic [1:0]                 htrans,
    output logic                       hwrite,
    output logic [2:0]                 hsize,
    output logic [RTF_DATA_W-1:0]      hwdata
);
    // Idle bus at time zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = RTF_HSIZE_WORD;
        hwdata = 32'h0;
    end

    // One single transfer, word sized unless size says otherwise; call right after a rising edge
    task automatic xfer(input logic [31:0] addr, input logic wr,
                        input logic [31:0] wdata, output logic [31:0] rdata,
                        input logic [2:0] size = RTF_HSIZE_WORD);
        hsel   <= 1'b1;
        haddr  <= addr;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= size;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        do @(posedge hclk); while (hready !== 1'b1);
        rdata = hrdata;
        // Released data is scrambled so stale values cannot pass
        hwdata <= ~wdata;
    endtask
endmodule
`default_nettype wire

// >>> tb/rtf_top_assertions.sv
// Port checks for the remote temperature result registers
`timescale 1ns/1ns
`default_nettype none
module rtf_top_assertions
    import rtf_pkg::*;
(
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire logic                  hsel,
    input wire logic [RTF_DATA_W-1:0] haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic [2:0]            hsize,
    input wire logic [RTF_DATA_W-1:0] hwdata,
    input wire logic                  hready,
    input wire logic                  hreadyout,
    input wire logic [RTF_DATA_W-1:0] hrdata,
    input wire logic                  hresp,
    input wire logic                  conv_valid,
    input wire logic [RTF_RAW_W-1:0]  conv_raw
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ************************************************
    // Helper state
    // ************************************************
    logic       take;
    logic       rd_map;
    logic       cfg_wr_q;
    logic [1:0] cfg_q;
    logic [1:0] conv_cfg_q;
    logic       s_hold_q;    // Signed high read, low byte still frozen
    logic       u_hold_q;    // Same for the unsigned pair
    logic [1:0] s_cfg_q;     // Config behind the frozen signed low byte
    logic [1:0] u_cfg_q;     // Config behind the frozen unsigned low byte
    logic [1:0] s_cfg;
    logic [1:0] u_cfg;
    assign take   = hsel && htrans[1] && hready;
    assign rd_map = take && !hwrite && haddr[31:12] == 20'h00000;
    // A low byte read after its high byte shows the older conversion
    assign s_cfg  = s_hold_q ? s_cfg_q : conv_cfg_q;
    assign u_cfg  = u_hold_q ? u_cfg_q : conv_cfg_q;

    // Config as seen by the last conversion, since bytes follow that edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_wr_q   <= 1'b0;
            cfg_q      <= 2'h0;
            conv_cfg_q <= 2'h0;
            s_hold_q   <= 1'b0;
            u_hold_q   <= 1'b0;
            s_cfg_q    <= 2'h0;
            u_cfg_q    <= 2'h0;
        end else begin
            // Pair tracking, so a conversion between reads cannot mislead
            if (rd_map && haddr[11:2] == RTF_IDX_SIGNED_HIGH) begin
                s_hold_q <= 1'b1;
                s_cfg_q  <= conv_cfg_q;
            end else if (rd_map && haddr[11:2] == RTF_IDX_SIGNED_LOW) begin
                s_hold_q <= 1'b0;
            end
            if (rd_map && haddr[11:2] == RTF_IDX_UNSIGNED_HIGH) begin
                u_hold_q <= 1'b1;
                u_cfg_q  <= conv_cfg_q;
            end else if (rd_map && haddr[11:2] == RTF_IDX_UNSIGNED_LOW) begin
                u_hold_q <= 1'b0;
            end
            cfg_wr_q <= take && hwrite && hsize == RTF_HSIZE_WORD &&
                        haddr[31:12] == 20'h00000 &&
                        haddr[11:2] == RTF_IDX_CONFIG;
            if (cfg_wr_q) begin
                cfg_q <= hwdata[1:0];
            end
            if (conv_valid) begin
                conv_cfg_q <= cfg_q;
            end
        end
    end

    // ************************************************
    // Assertions
    // ************************************************
    sequence s_rd(logic [RTF_IDX_W-1:0] idx);
        take && !hwrite && haddr[31:12] == 20'h00000 && haddr[11:2] == idx;
    endsequence

    a_bus_okay: assert property (hreadyout && hresp == RTF_HRESP_OKAY)
        else $error("bus stalled or errored");
    a_unmapped_zero: assert property (take && !hwrite &&
        haddr[31:12] != 20'h00000 |=> hrdata == RTF_DATA_ZERO)
        else $error("unmapped read not zero");
    a_upper_zero: assert property (take && !hwrite |=> hrdata[31:8] == 24'h0)
        else $error("read data above byte not zero");
    a_hrdata_hold: assert property (!(take && !hwrite) |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_sgn_unused: assert property (
        s_rd(RTF_IDX_SIGNED_LOW) |=> hrdata[2:0] == RTF_UNUSED_VAL)
        else $error("signed low unused bits set");
    a_uns_unused: assert property (
        s_rd(RTF_IDX_UNSIGNED_LOW) |=> hrdata[2:0] == RTF_UNUSED_VAL)
        else $error("unsigned low unused bits set");
    a_sgn_fine_off: assert property (
        s_rd(RTF_IDX_SIGNED_LOW) ##0 !s_cfg[RTF_CFG_EXT_BIT]
        |=> hrdata[4:3] == RTF_FRAC_ZERO)
        else $error("signed fine bits set without extension");
    a_ext_flag: assert property (
        s_rd(RTF_IDX_SIGNED_LOW) ##0 s_cfg == 2'h1
        |=> hrdata[4:3] == RTF_FRAC_ZERO || hrdata[4:3] == RTF_FRAC_ONES)
        else $error("extension flag bits not equal");
    a_uns_fine_off: assert property (
        s_rd(RTF_IDX_UNSIGNED_LOW) ##0 !u_cfg[RTF_CFG_FILT_BIT]
        |=> hrdata[4:3] == RTF_FRAC_ZERO)
        else $error("unsigned fine bits set with filter off");
endmodule
`default_nettype wire

// >>> tb/rtf_top_tb.sv
// Self-checking bench for the remote temperature result registers
`timescale 1ns/1ns
`default_nettype none
module rtf_top_tb;
    import rtf_pkg::*;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        conv_valid;
    logic [13:0] conv_raw;
    logic [31:0] e;
    logic [31:0] g;
    int          fail_count;
    int          check_count;
    int          raws[6]    = '{818, -100, 4094, 4092, 8000, -8192};
    int          ofs_tab[3] = '{0, -12, 40};

    initial hclk = 1'b0;
    always #20 hclk = ~hclk;

    rtf_top u_rtf_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .conv_valid(conv_valid),
        .conv_raw(conv_raw));
    rtf_host u_rtf_host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata));

    // ************************************************
    // Tasks
    // ************************************************
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: read %h not %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
        u_rtf_host.xfer({20'h0, idx, 2'h0}, 1'b0, 32'h0, g);
        cmp(g, {24'h0, exp});
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] val);
        u_rtf_host.xfer({20'h0, idx, 2'h0}, 1'b1, {24'h0, val}, g);
    endtask

    task automatic conv(input int raw);
        conv_raw   <= raw[13:0];
        conv_valid <= 1'b1;
        @(posedge hclk);
        conv_valid <= 1'b0;
    endtask

    function automatic logic [31:0] expv(int raw, int ofs, logic ext,
                                         logic filt);
        int         s;
        int         sc;
        int         uc;
        logic [1:0] sf;
        s  = raw + ofs * 4;
        sc = s > 4095 ? 4095 : (s < -4096 ? -4096 : s);
        uc = s > 8191 ? 8191 : (s < 0 ? 0 : s);
        sf = !ext ? 2'h0 : (filt ? sc[1:0] : (s > 4092 ? 2'h3 : 2'h0));
        return {sc[12:2], sf, 3'h0, uc[12:2], filt ? uc[1:0] : 2'h0, 3'h0};
    endfunction

    task automatic report_and_stop();
        if (fail_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Watchdog, far beyond the fewer than a thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        $display("unexpected at %0t: run timed out", $time);
        report_and_stop();
    end

    // ************************************************
    // Tests
    // ************************************************
    initial begin
        hresetn     = 1'b0;
        conv_valid  = 1'b0;
        conv_raw    = 14'h0;
        fail_count  = 0;
        check_count = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(RTF_IDX_SIGNED_HIGH, 8'h00);
        rd_chk(RTF_IDX_SIGNED_LOW, 8'h00);
        rd_chk(RTF_IDX_UNSIGNED_HIGH, 8'h00);
        rd_chk(RTF_IDX_UNSIGNED_LOW, 8'h00);
        rd_chk(RTF_IDX_CONFIG, 8'h00);
        // Results are read-only, offset low keeps only bits 7:5
        wr(RTF_IDX_SIGNED_HIGH, 8'h7F);
        rd_chk(RTF_IDX_SIGNED_HIGH, 8'h00);
        wr(RTF_IDX_OFFSET_LOW, 8'hFF);
        rd_chk(RTF_IDX_OFFSET_LOW, 8'hE0);
        // Byte-sized writes are dropped, so config stays clear
        u_rtf_host.xfer({20'h0, RTF_IDX_CONFIG, 2'h0}, 1'b1, 32'h3, g, 3'h0);
        rd_chk(RTF_IDX_CONFIG, 8'h00);
        u_rtf_host.xfer(32'h00001004, 1'b0, 32'h0, g);
        cmp(g, 32'h0);
        // Every config mode, offset and boundary reading; high before low
        foreach (ofs_tab[o]) begin
            for (int c = 0; c < 4; c++) begin
                wr(RTF_IDX_CONFIG, c[7:0]);
                wr(RTF_IDX_OFFSET_HIGH, ofs_tab[o][10:3]);
                wr(RTF_IDX_OFFSET_LOW, {ofs_tab[o][2:0], 5'h00});
                foreach (raws[r]) begin
                    conv(raws[r]);
                    e = expv(raws[r], ofs_tab[o], c[0], c[1]);
                    rd_chk(RTF_IDX_SIGNED_HIGH, e[31:24]);
                    rd_chk(RTF_IDX_SIGNED_LOW, e[23:16]);
                    rd_chk(RTF_IDX_UNSIGNED_HIGH, e[15:8]);
                    rd_chk(RTF_IDX_UNSIGNED_LOW, e[7:0]);
                end
            end
        end
        // Low byte stays with the high byte read before a new result
        conv(818);
        e = expv(818, 40, 1'b1, 1'b1);
        rd_chk(RTF_IDX_SIGNED_HIGH, e[31:24]);
        rd_chk(RTF_IDX_UNSIGNED_HIGH, e[15:8]);
        conv(-100);
        rd_chk(RTF_IDX_SIGNED_LOW, e[23:16]);
        rd_chk(RTF_IDX_UNSIGNED_LOW, e[7:0]);
        e = expv(-100, 40, 1'b1, 1'b1);
        rd_chk(RTF_IDX_SIGNED_LOW, e[23:16]);
        rd_chk(RTF_IDX_UNSIGNED_HIGH, e[15:8]);
        report_and_stop();
    end
endmodule

bind rtf_top rtf_top_assertions u_rtf_top_assertions (.hclk, .hresetn,
    .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hrdata, .hresp, .conv_valid, .conv_raw);
`default_nettype wire
